// file: general_timer_and_free_counter.sv
// General purpose 16-bit down timer and free-running 32-bit tick counter.
// Assumes an APB master on clk_i; APB inputs are synchronous to clk_i.
`timescale 1ns/1ns
`include "timer_defs.svh"

module general_timer_and_free_counter
   import timer_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic             irq_o
);

   timer_state_t st;
   timer_state_t next_st;
   logic         free_tick;
   logic         setup;
   logic         access;
   logic         wr;
   logic         wr_cfg;
   logic         timer_evt;
   logic [31:0]  read_word;

   // Decodes whether an address holds a register; used for the error response and the checks
   function automatic logic addr_ok(input logic [11:0] a);
      case (a)
         `REG_TIMER_CONFIG,
         `REG_TIMER_CURRENT,
         `REG_FREE_RUNNING_TICK,
         `REG_INT_STATUS,
         `REG_INT_MASK,
         `REG_BUS_MODE,
         `REG_FREE_RUNNING_HIGH: addr_ok = 1'b1;
         default:                addr_ok = 1'b0;
      endcase
   endfunction

   // Single 25 MHz enable shared by both counters
   tick_divider u_div (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .tick_o  (free_tick)
   );

   // Read multiplexer; reserved bits read as zero
   always_comb begin
      case (paddr_i)
         `REG_TIMER_CONFIG: begin
            read_word = 32'h0;
            read_word[`CFG_RUN_BIT] = st.run;
            read_word[15:0] = st.preload;
         end
         `REG_TIMER_CURRENT:     read_word = {16'h0, st.count};
         `REG_FREE_RUNNING_TICK: begin
            // Half mode returns the low half of the value being latched
            read_word = st.half_mode ? {16'h0, st.free[15:0]} : st.free;
         end
         `REG_FREE_RUNNING_HIGH: read_word = {16'h0, st.latch[31:16]};
         `REG_INT_STATUS:        read_word = {31'h0, st.status};
         `REG_INT_MASK:          read_word = {31'h0, st.mask};
         `REG_BUS_MODE:          read_word = {31'h0, st.half_mode};
         default:                read_word = 32'h0;
      endcase
   end

   // Next state of the whole block
   always_comb begin
      next_st   = st;
      setup     = psel_i && !penable_i;
      access    = psel_i && penable_i && st.pready;
      wr        = access && pwrite_i;
      wr_cfg    = wr && (paddr_i == `REG_TIMER_CONFIG);
      timer_evt = 1'b0;

      // Never gated by power state, reset is the only thing that stops it
      if (free_tick) begin
         next_st.free = st.free + 32'h1;
      end

      // Answer prepared during setup so outputs leave flops with one wait-free access
      next_st.pready = setup;
      if (setup) begin
         next_st.pslverr = !addr_ok(paddr_i);
         next_st.prdata  = pwrite_i ? 32'h0 : read_word;
         // Capture once so both halves describe the same instant
         if (!pwrite_i && st.half_mode && (paddr_i == `REG_FREE_RUNNING_TICK)) begin
            next_st.latch = st.free;
         end
      end

      // Register writes take effect at the access edge
      if (wr_cfg) begin
         next_st.run     = pwdata_i[`CFG_RUN_BIT];
         next_st.preload = pwdata_i[15:0];
      end
      if (wr && (paddr_i == `REG_INT_MASK)) begin
         next_st.mask = pwdata_i[`INT_TIMER_BIT];
      end
      if (wr && (paddr_i == `REG_BUS_MODE)) begin
         next_st.half_mode = pwdata_i[`MODE_HALF_BIT];
      end

      // Halting presets the preload regardless of the value just written
      if (st.run && !next_st.run) begin
         next_st.preload = `PRELOAD_RESET;
      end

      // Timer: load on start, count down while running, reload on underflow
      if (!st.run && next_st.run) begin
         next_st.count = next_st.preload;
      end else if (st.run && next_st.run && free_tick) begin
         if (st.count == 16'h0) begin
            next_st.count = st.preload;
            timer_evt     = 1'b1;
         end else begin
            next_st.count = st.count - 16'h1;
         end
      end

      // Write one to clear; a same-cycle event wins over the clear
      if (wr && (paddr_i == `REG_INT_STATUS) && pwdata_i[`INT_TIMER_BIT]) begin
         next_st.status = 1'b0;
      end
      if (timer_evt) begin
         next_st.status = 1'b1;
      end
      next_st.irq = next_st.status && next_st.mask;
   end

   // State register; the free counter clears at once, well inside the settle time
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st           <= '0;
         st.preload   <= `PRELOAD_RESET;
         st.count     <= `COUNT_RESET;
         st.free      <= `FREE_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign prdata_o  = st.prdata;
   assign pready_o  = st.pready;
   assign pslverr_o = st.pslverr;
   assign irq_o     = st.irq;

   // Cycles since reset release, saturating; only the checks read it
   logic [7:0] since_rst;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         since_rst <= 8'h0;
      end else if (since_rst != 8'hff) begin
         since_rst <= since_rst + 8'h1;
      end
   end

   // Checks
   property p_halt_hold;
      @(posedge clk_i) disable iff (!rst_n_i)
         (!st.run && !next_st.run) |=> (st.count == $past(st.count));
   endproperty
   a_halt_hold: assert property (p_halt_hold) else $error("halted timer moved");

   property p_stop_preset;
      @(posedge clk_i) disable iff (!rst_n_i)
         $fell(st.run) |-> (st.preload == 16'hffff);
   endproperty
   a_stop_preset: assert property (p_stop_preset) else $error("preload not preset");

   property p_preload_write;
      @(posedge clk_i) disable iff (!rst_n_i)
         (wr_cfg && !(st.run && !pwdata_i[`CFG_RUN_BIT]))
            |=> (st.preload == $past(pwdata_i[15:0]));
   endproperty
   a_preload_write: assert property (p_preload_write) else $error("preload lost");

   property p_underflow_irq;
      @(posedge clk_i) disable iff (!rst_n_i)
         (st.run && free_tick && st.count == 16'h0 && !wr_cfg)
            |=> (st.status && st.count == $past(st.preload)) ##0 (irq_o == st.mask);
   endproperty
   a_underflow_irq: assert property (p_underflow_irq) else $error("no reload or flag");

   property p_count_read;
      @(posedge clk_i) disable iff (!rst_n_i)
         (setup && !pwrite_i && paddr_i == `REG_TIMER_CURRENT)
            |=> (prdata_o == {16'h0, $past(st.count)}) && pready_o;
   endproperty
   a_count_read: assert property (p_count_read) else $error("bad count read");

   property p_free_step;
      @(posedge clk_i) disable iff (!rst_n_i)
         free_tick |=> (st.free == $past(st.free) + 32'h1) ##1 (st.free == $past(st.free));
   endproperty
   a_free_step: assert property (p_free_step) else $error("free counter step wrong");

   property p_free_wrap;
      @(posedge clk_i) disable iff (!rst_n_i)
         (free_tick && st.free == 32'hffff_ffff) |=> (st.free == 32'h0);
   endproperty
   a_free_wrap: assert property (p_free_wrap) else $error("free counter no wrap");

   property p_half_pair;
      @(posedge clk_i) disable iff (!rst_n_i)
         (setup && !pwrite_i && paddr_i == `REG_FREE_RUNNING_HIGH)
            |=> (prdata_o[15:0] == $past(st.latch[31:16]));
   endproperty
   a_half_pair: assert property (p_half_pair) else $error("high half not latched");

   property p_settle;
      @(posedge clk_i) disable iff (!rst_n_i)
         (since_rst < 8'(`FREE_SETTLE_CYC)) |-> (st.free <= 32'(since_rst));
   endproperty
   a_settle: assert property (p_settle) else $error("free counter not cleared");

   property p_start_load;
      @(posedge clk_i) disable iff (!rst_n_i)
         $rose(st.run) |-> (st.count == st.preload);
   endproperty
   a_start_load: assert property (p_start_load) else $error("start did not load");

   property p_count_down;
      @(posedge clk_i) disable iff (!rst_n_i)
         (st.run && free_tick && st.count != 16'h0 && !wr_cfg)
            |=> (st.count == $past(st.count) - 16'h1);
   endproperty
   a_count_down: assert property (p_count_down) else $error("timer did not step");

   // Access phase is exactly one cycle, so the master never waits
   property p_setup_answer;
      @(posedge clk_i) disable iff (!rst_n_i)
         setup |=> pready_o;
   endproperty
   a_setup_answer: assert property (p_setup_answer) else $error("no answer to setup");

   property p_pready_pulse;
      @(posedge clk_i) disable iff (!rst_n_i)
         pready_o |=> !pready_o;
   endproperty
   a_pready_pulse: assert property (p_pready_pulse) else $error("pready held too long");

   // Unmapped addresses answer with an error and read as zero
   property p_unmapped_err;
      @(posedge clk_i) disable iff (!rst_n_i)
         (setup && !addr_ok(paddr_i)) |=> (pslverr_o && pready_o && prdata_o == 32'h0);
   endproperty
   a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped not refused");

   // Clear only takes when no underflow lands in the same cycle
   property p_w1c_clear;
      @(posedge clk_i) disable iff (!rst_n_i)
         (wr && paddr_i == `REG_INT_STATUS && pwdata_i[`INT_TIMER_BIT] && !timer_evt)
            |=> !st.status && !irq_o;
   endproperty
   a_w1c_clear: assert property (p_w1c_clear) else $error("status not cleared");

   property p_set_wins;
      @(posedge clk_i) disable iff (!rst_n_i)
         timer_evt |=> st.status;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

   // The count register is read-only; a write must not disturb a halted count
   property p_ro_ignore;
      @(posedge clk_i) disable iff (!rst_n_i)
         (wr && paddr_i == `REG_TIMER_CURRENT && !st.run) |=> (st.count == $past(st.count));
   endproperty
   a_ro_ignore: assert property (p_ro_ignore) else $error("count took a write");

   // Both halves come from the value captured at the low-half read
   property p_latch_take;
      @(posedge clk_i) disable iff (!rst_n_i)
         (setup && !pwrite_i && st.half_mode && paddr_i == `REG_FREE_RUNNING_TICK)
            |=> (st.latch == $past(st.free)) && (prdata_o[15:0] == st.latch[15:0]);
   endproperty
   a_latch_take: assert property (p_latch_take) else $error("latch not taken");

   // One enable pulse every four system clocks gives the 25 MHz rate
   property p_tick_period;
      @(posedge clk_i) disable iff (!rst_n_i)
         free_tick |=> (!free_tick) [*3] ##1 free_tick;
   endproperty
   a_tick_period: assert property (p_tick_period) else $error("tick rate wrong");

   // Main scenarios
   c_underflow: cover property (@(posedge clk_i) disable iff (!rst_n_i) timer_evt && st.mask);
   c_halt: cover property (@(posedge clk_i) disable iff (!rst_n_i) $fell(st.run));
   c_half_read: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      setup && st.half_mode && paddr_i == `REG_FREE_RUNNING_HIGH);
   c_unmapped: cover property (@(posedge clk_i) disable iff (!rst_n_i) pslverr_o && pready_o);
   c_ro_write: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      wr && paddr_i == `REG_TIMER_CURRENT);

endmodule

// file: timer_defs.svh
// Constants for the general purpose timer and free-running tick counter.
// Assumes a 100 MHz system clock and a 32-bit APB register bus.
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// Register byte addresses
`define REG_TIMER_CONFIG       12'h08c
`define REG_TIMER_CURRENT      12'h090
`define REG_FREE_RUNNING_TICK  12'h09c
`define REG_INT_STATUS         12'h0e0
`define REG_INT_MASK           12'h0e4
`define REG_BUS_MODE           12'h0e8
`define REG_FREE_RUNNING_HIGH  12'h0ec

// Field positions
`define CFG_RUN_BIT            29
`define INT_TIMER_BIT          0
`define MODE_HALF_BIT          0

// Reset values
`define PRELOAD_RESET          16'hffff
`define COUNT_RESET            16'hffff
`define FREE_RESET             32'h0000_0000

// Timing
`define CLK_MHZ                100
`define FREE_TICK_MHZ          25
`define FREE_TICK_DIV          (`CLK_MHZ / `FREE_TICK_MHZ)
`define FREE_SETTLE_NS         160
`define FREE_SETTLE_CYC        ((`FREE_SETTLE_NS * `CLK_MHZ) / 1000)

`endif

// file: timer_pkg.sv
// Types shared by the timer block and its tick divider.
// Assumes timer_defs.svh supplies the numeric constants.
package timer_pkg;

   // State of the 25 MHz enable divider
   typedef struct packed {
      logic [1:0] phase;
      logic       tick;
   } div_state_t;

   // Whole state of the timer block
   typedef struct packed {
      logic        run;
      logic [15:0] preload;
      logic [15:0] count;
      logic [31:0] free;
      logic [31:0] latch;
      logic        half_mode;
      logic        status;
      logic        mask;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        irq;
   } timer_state_t;

endpackage

// file: tick_divider.sv
// Divider giving a one-cycle 25 MHz enable pulse from the system clock.
// Assumes clk_i at 100 MHz; the pulse is registered.
`timescale 1ns/1ns
`include "timer_defs.svh"

module tick_divider
   import timer_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   output logic      tick_o
);

   div_state_t st;
   div_state_t next_st;

   // Count phases; the last phase sets the pulse, which is high during the following phase 0
   always_comb begin
      next_st = st;
      if (st.phase == 2'(`FREE_TICK_DIV - 1)) begin
         next_st.phase = 2'h0;
         next_st.tick  = 1'b1;
      end else begin
         next_st.phase = st.phase + 2'h1;
         next_st.tick  = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tick_o = st.tick;

endmodule

// file: general_timer_and_free_counter_bench.sv
// Self-checking bench for the timer and free-running tick counter.
// Assumes the design answers each APB transfer and drives irq_o from status and mask bit 0.
`timescale 1ns/1ns
`include "timer_defs.svh"

module general_timer_and_free_counter_bench;
   logic        clk_i       = 1'b0;
   logic        rst_n_i     = 1'b0;
   logic        psel_i      = 1'b0;
   logic        penable_i   = 1'b0;
   logic        pwrite_i    = 1'b0;
   logic [11:0] paddr_i     = 12'h000;
   logic [31:0] pwdata_i    = 32'h0000_0000;
   logic [31:0] prdata_o;
   logic        pready_o;
   logic        pslverr_o;
   logic        irq_o;
   logic [31:0] rd;
   logic        err;
   logic [31:0] v0;
   logic [31:0] v1;
   int          n_errors    = 0;
   int          comparisons = 0;
   int          cyc         = 0;
   int          t0;
   int          t1;

   general_timer_and_free_counter dut (
      .clk_i     (clk_i),
      .rst_n_i   (rst_n_i),
      .psel_i    (psel_i),
      .penable_i (penable_i),
      .pwrite_i  (pwrite_i),
      .paddr_i   (paddr_i),
      .pwdata_i  (pwdata_i),
      .prdata_o  (prdata_o),
      .pready_o  (pready_o),
      .pslverr_o (pslverr_o),
      .irq_o     (irq_o)
   );

   // 100 MHz clock
   always #5 clk_i = ~clk_i;

   // Hang guard; the tests need well under a thousand cycles
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors = n_errors + 1;
         end_of_test();
      end
   end

   // Verdict and end of run
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Compare one value, case equality so an unknown never matches
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One APB transfer; the answer is read mid-cycle, where the flops have settled,
   // and the request is released only after the rising edge that samples pready_o high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int   w;
      logic seen;
      w = 0;
      seen = 1'b0;
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      // Reading at the clock edge itself would race the design's output flops
      do begin
         @(negedge clk_i);
         w++;
         seen = pready_o;
         rd = prdata_o;
         err = pslverr_o;
         @(posedge clk_i);
      end while (seen !== 1'b1 && w < 50);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      check("pready seen", 32'd1, {31'd0, seen});
   endtask

   // Wait for irq_o high, bounded; the time stamp is the edge that raised it
   task automatic wait_irq(output int t);
      int w;
      w = 0;
      do begin
         @(posedge clk_i);
         #1;
         w++;
      end while (irq_o !== 1'b1 && w < 100);
      t = cyc;
   endtask

   task automatic t_reset();
      apb(1'b0, `REG_TIMER_CONFIG, 32'h0);
      check("config reset", 32'h0000_ffff, rd);
      apb(1'b0, `REG_TIMER_CURRENT, 32'h0);
      check("count reset", 32'h0000_ffff, rd);
      apb(1'b0, `REG_INT_STATUS, 32'h0);
      check("status reset", 32'h0, rd);
      $display("test reset done");
   endtask

   // Short period, interrupt masking, W1C clear, halt and preload force
   task automatic t_timer();
      apb(1'b1, `REG_INT_MASK, 32'h1);
      apb(1'b1, `REG_TIMER_CONFIG, 32'h2000_0003);
      apb(1'b0, `REG_TIMER_CURRENT, 32'h0);
      check("count loaded", 32'd1, {31'd0, rd <= 32'd3});
      wait_irq(t0);
      apb(1'b1, `REG_INT_STATUS, 32'h1);
      #1;
      check("irq cleared", 32'd0, {31'd0, irq_o});
      wait_irq(t1);
      check("period cycles", 32'd16, t1 - t0);
      apb(1'b1, `REG_INT_MASK, 32'h0);
      apb(1'b1, `REG_INT_STATUS, 32'h1);
      repeat (20) @(posedge clk_i);
      #1;
      check("irq masked", 32'd0, {31'd0, irq_o});
      apb(1'b0, `REG_INT_STATUS, 32'h0);
      check("status sticky", 32'h1, rd);
      apb(1'b1, `REG_INT_MASK, 32'h1);
      #1;
      check("irq unmasked", 32'd1, {31'd0, irq_o});
      // Written preload 5 must lose to the forced value on the falling run bit
      apb(1'b1, `REG_TIMER_CONFIG, 32'h0000_0005);
      apb(1'b0, `REG_TIMER_CONFIG, 32'h0);
      check("preload forced", 32'h0000_ffff, rd);
      apb(1'b0, `REG_TIMER_CURRENT, 32'h0);
      v0 = rd;
      repeat (20) @(posedge clk_i);
      apb(1'b1, `REG_TIMER_CURRENT, 32'h0000_1234);
      apb(1'b0, `REG_TIMER_CURRENT, 32'h0);
      check("count halted", v0, rd);
      apb(1'b0, 12'h004, 32'h0);
      check("unmapped err", 32'd1, {31'd0, err});
      check("unmapped data", 32'h0, rd);
      apb(1'b1, `REG_INT_STATUS, 32'h1);
      $display("test timer done");
   endtask

   // Half mode: two latched reads whose setup edges are 40 cycles apart
   task automatic t_free();
      apb(1'b1, `REG_BUS_MODE, 32'h1);
      apb(1'b0, `REG_FREE_RUNNING_TICK, 32'h0);
      v0[15:0] = rd[15:0];
      apb(1'b0, `REG_FREE_RUNNING_HIGH, 32'h0);
      v0[31:16] = rd[15:0];
      repeat (34) @(posedge clk_i);
      apb(1'b0, `REG_FREE_RUNNING_TICK, 32'h0);
      v1[15:0] = rd[15:0];
      apb(1'b0, `REG_FREE_RUNNING_HIGH, 32'h0);
      v1[31:16] = rd[15:0];
      check("free ticks", 32'd10, v1 - v0);
      $display("test free done");
   endtask

   // Reset for 4 cycles, then the scenarios in order
   initial begin
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_reset();
      t_timer();
      t_free();
      end_of_test();
   end
endmodule
